// >>> rtl/dsir_top.sv
// How it works
// R01: Each channel's sync field in its sync/frame register picks its trigger event.
// R02: Code 0000b lets the channel run with no sync event.
// R03: Codes 0001b/0010b pick serial port zero receive/transmit events.
// R04: Codes 0101b/0110b pick serial port one receive/transmit events.
// R05: Codes 1101b, 1110b, 1111b pick timer 0, external irq 3, timer 1.
// R06: Software must not program reserved sync codes; they select nothing here.
// R07: Every channel can interrupt; channels 0-3 only through shared lines.
// R08: Channels 2 and 3 share lines 10 and 11 with port one rx/tx.
// R09: Channel 1 shares line 7 with timer 1; channel 0 line 6 with reserved.
// R10: Reset clears the routing field; lines carry the peripheral sources.
// R11: Routing 01b gives channels 2-3, 10b channels 0-3, 11b reserved.
// R12: Priority and enable register sits at data address 54h.
// R13: Subbank pointer sits at data address 55h.
// R14: Data ports at 56h (auto-increment) and 57h (plain) reach the pointed register.
// R15: An access at 56h bumps the pointer afterwards; 57h leaves it.
// R16: Channel irq off when enable 0; else block end, plus half/frame when mode 1.
// R17: Channels 4 and 5 drive their own interrupt lines regardless of routing.
// R18: A synced channel waits for one selected event before each transfer.
`timescale 1ns/1ps
`include "dsir_regs.svh"

module dsir_top
    import dsir_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire dsir_bus_req_t i_bus,
    output logic [15:0] o_rdata,
    output logic o_rd_valid,
    output logic o_hit,
    input wire dsir_evt_t i_evt,
    input wire dsir_irq_src_t i_src,
    input wire logic [DSIR_CHANS-1:0] i_chan_half_end,
    input wire logic [DSIR_CHANS-1:0] i_chan_block_end,
    input wire logic [DSIR_CHANS-1:0] i_chan_xfer_done,
    output logic [DSIR_CHANS-1:0] o_chan_xfer_go,
    output logic [DSIR_CHANS-1:0] o_chan_irq,
    output logic [1:0] o_route,
    output dsir_cpu_irq_t o_cpu_irq
);

    logic [15:0] dma_priority_enable_ctrl_q;
    logic [15:0] dma_subbank_pointer_q;
    logic [15:0] dma_subbank_pointer_d;
    logic [15:0] rdata_d;
    logic [15:0] sb_rdata;
    logic [DSIR_CHANS*4-1:0] sync_sel;
    logic [DSIR_CHANS-1:0] chan_irq_enable;
    logic [DSIR_CHANS-1:0] chan_irq_mode;
    logic [DSIR_CHANS-1:0] chan_en;
    logic [DSIR_CHANS-1:0] evt_hit;
    logic [DSIR_CHANS-1:0] evt_pend_q;
    logic [DSIR_CHANS-1:0] chan_irq_d;
    logic [DSIR_CHANS-1:0] chan_irq_q;
    logic sel_prio;
    logic sel_ptr;
    logic sel_autoinc;
    logic sel_plain;
    logic acc;
    logic sb_wr;
    dsir_route_t dma_irq_route_select;
    dsir_cpu_irq_t cpu_irq_d;
    dsir_cpu_irq_t cpu_irq_q;

    // Address decode of the four direct entry points
    always_comb begin
        sel_prio = 1'b0;
        sel_ptr = 1'b0;
        sel_autoinc = 1'b0;
        sel_plain = 1'b0;
        if (i_bus.addr == `DSIR_ADDR_PRIO_EN) begin
            sel_prio = 1'b1; // R12
        end else if (i_bus.addr == `DSIR_ADDR_SB_PTR) begin
            sel_ptr = 1'b1; // R13
        end else if (i_bus.addr == `DSIR_ADDR_SB_AUTOINC) begin
            sel_autoinc = 1'b1; // R14
        end else if (i_bus.addr == `DSIR_ADDR_SB_PLAIN) begin
            sel_plain = 1'b1; // R14
        end
    end

    assign acc = i_bus.rd | i_bus.wr;
    assign o_hit = sel_prio | sel_ptr | sel_autoinc | sel_plain;
    assign sb_wr = i_bus.wr & (sel_autoinc | sel_plain); // R14

    // Priority and enable register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            dma_priority_enable_ctrl_q <= `DSIR_PRIO_EN_RST; // R10
        end else if (i_bus.wr && sel_prio) begin
            dma_priority_enable_ctrl_q <= i_bus.wdata;
        end
    end

    assign dma_irq_route_select = dsir_route_t'(
        dma_priority_enable_ctrl_q[`DSIR_ROUTE_MSB:`DSIR_ROUTE_LSB]); // R11
    assign chan_en = dma_priority_enable_ctrl_q[`DSIR_CHEN_LSB +: DSIR_CHANS];
    assign o_route = dma_priority_enable_ctrl_q[`DSIR_ROUTE_MSB:`DSIR_ROUTE_LSB];

    // Pointer: a direct write loads it, an auto-increment access bumps it
    always_comb begin
        dma_subbank_pointer_d = dma_subbank_pointer_q;
        if (i_bus.wr && sel_ptr) begin
            dma_subbank_pointer_d = i_bus.wdata;
        end else if (acc && sel_autoinc) begin
            dma_subbank_pointer_d = dma_subbank_pointer_q + 16'h0001; // R15
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            dma_subbank_pointer_q <= `DSIR_SB_PTR_RST;
        end else begin
            dma_subbank_pointer_q <= dma_subbank_pointer_d;
        end
    end

    dsir_subbank u_subbank (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_wr(sb_wr),
        .i_addr(dma_subbank_pointer_q),
        .i_wdata(i_bus.wdata),
        .o_rdata(sb_rdata),
        .o_sync_sel(sync_sel),
        .o_irq_en(chan_irq_enable),
        .o_irq_mode(chan_irq_mode)
    );

    // Read data uses the pointer before any increment of the same access
    always_comb begin
        rdata_d = 16'h0000;
        if (sel_prio) begin
            rdata_d = dma_priority_enable_ctrl_q;
        end else if (sel_ptr) begin
            rdata_d = dma_subbank_pointer_q;
        end else if (sel_autoinc || sel_plain) begin
            rdata_d = sb_rdata; // R14
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_bus.rd;
            if (i_bus.rd) begin
                o_rdata <= rdata_d;
            end
        end
    end

    // Event selection per channel
    always_comb begin
        evt_hit = '0;
        for (int c = 0; c < DSIR_CHANS; c++) begin
            evt_hit[c] = dsir_pick_event(sync_sel[c*4 +: 4], i_evt); // R01 R03 R04 R05 R06
        end
    end

    // One pending event per channel; an event in the done cycle is kept
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            evt_pend_q <= '0;
        end else begin
            for (int c = 0; c < DSIR_CHANS; c++) begin
                if (evt_hit[c]) begin
                    evt_pend_q[c] <= 1'b1; // R18
                end else if (i_chan_xfer_done[c]) begin
                    evt_pend_q[c] <= 1'b0; // R18
                end
            end
        end
    end

    always_comb begin
        o_chan_xfer_go = '0;
        for (int c = 0; c < DSIR_CHANS; c++) begin
            if (sync_sel[c*4 +: 4] == DSIR_SYNC_NONE) begin
                o_chan_xfer_go[c] = chan_en[c]; // R02
            end else begin
                o_chan_xfer_go[c] = chan_en[c] & evt_pend_q[c]; // R18
            end
        end
    end

    // Per-channel interrupt from the mode bits
    always_comb begin
        chan_irq_d = '0;
        for (int c = 0; c < DSIR_CHANS; c++) begin
            chan_irq_d[c] = chan_irq_enable[c] &
                (i_chan_block_end[c] | (chan_irq_mode[c] & i_chan_half_end[c])); // R16
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            chan_irq_q <= '0;
        end else begin
            chan_irq_q <= chan_irq_d; // R07
        end
    end

    assign o_chan_irq = chan_irq_q;

    // Shared line routing; reserved routing code behaves like reset
    always_comb begin
        cpu_irq_d.line6 = i_src.rsvd6_irq;
        cpu_irq_d.line7 = i_src.timer1_irq;
        cpu_irq_d.line10 = i_src.port1_rx_irq;
        cpu_irq_d.line11 = i_src.port1_tx_irq; // R10
        cpu_irq_d.dma_chan4_irq = chan_irq_q[4]; // R17
        cpu_irq_d.dma_chan5_irq = chan_irq_q[5]; // R17
        case (dma_irq_route_select)
            DSIR_ROUTE_CH23: begin
                cpu_irq_d.line10 = chan_irq_q[2]; // R08
                cpu_irq_d.line11 = chan_irq_q[3]; // R08
            end
            DSIR_ROUTE_ALL: begin
                cpu_irq_d.line6 = chan_irq_q[0]; // R09
                cpu_irq_d.line7 = chan_irq_q[1]; // R09
                cpu_irq_d.line10 = chan_irq_q[2]; // R08
                cpu_irq_d.line11 = chan_irq_q[3]; // R08
            end
            default: begin
                cpu_irq_d.line6 = i_src.rsvd6_irq; // R11
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cpu_irq_q <= '0;
        end else begin
            cpu_irq_q <= cpu_irq_d; // R07
        end
    end

    assign o_cpu_irq = cpu_irq_q;

endmodule // dsir_top

// >>> rtl/dsir_regs.svh
`ifndef DSIR_REGS_SVH
`define DSIR_REGS_SVH

// Direct data-memory addresses of the DMA control entry points
`define DSIR_ADDR_PRIO_EN 8'h54
`define DSIR_ADDR_SB_PTR 8'h55
`define DSIR_ADDR_SB_AUTOINC 8'h56
`define DSIR_ADDR_SB_PLAIN 8'h57

// Reset values
`define DSIR_PRIO_EN_RST 16'h0000
`define DSIR_SB_PTR_RST 16'h0000
`define DSIR_SB_DATA_RST 16'h0000

// Priority and enable register fields
`define DSIR_CHEN_LSB 0
`define DSIR_ROUTE_LSB 6
`define DSIR_ROUTE_MSB 7

// Subbank layout: five registers per channel, then common ones
`define DSIR_SB_COUNT 40
`define DSIR_SB_LAST 16'h0027
`define DSIR_SB_STRIDE 5
`define DSIR_SB_SFC_OFS 3
`define DSIR_SB_MCR_OFS 4

// Field positions inside the channel registers
`define DSIR_SFC_SYNC_LSB 12
`define DSIR_SFC_SYNC_MSB 15
`define DSIR_MCR_IRQMODE_BIT 13
`define DSIR_MCR_IRQEN_BIT 14

`endif

// >>> rtl/dsir_pkg.sv
package dsir_pkg;

    localparam int DSIR_CHANS = 6;

    typedef enum logic [1:0] {
        DSIR_ROUTE_NONE = 2'h0,
        DSIR_ROUTE_CH23 = 2'h1,
        DSIR_ROUTE_ALL = 2'h2,
        DSIR_ROUTE_RSVD = 2'h3
    } dsir_route_t;

    typedef enum logic [3:0] {
        DSIR_SYNC_NONE = 4'h0,
        DSIR_SYNC_P0_RX = 4'h1,
        DSIR_SYNC_P0_TX = 4'h2,
        DSIR_SYNC_P1_RX = 4'h5,
        DSIR_SYNC_P1_TX = 4'h6,
        DSIR_SYNC_TMR0 = 4'hD,
        DSIR_SYNC_EXT3 = 4'hE,
        DSIR_SYNC_TMR1 = 4'hF
    } dsir_sync_t;

    // One CPU access to the memory-mapped page
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } dsir_bus_req_t;

    // Synchronisation event pulses from the peripherals
    typedef struct packed {
        logic port0_rx;
        logic port0_tx;
        logic port1_rx;
        logic port1_tx;
        logic timer0_irq;
        logic ext_irq3;
        logic timer1_irq;
    } dsir_evt_t;

    // Sources that share the CPU lines with the DMA channels
    typedef struct packed {
        logic rsvd6_irq;
        logic timer1_irq;
        logic port1_rx_irq;
        logic port1_tx_irq;
    } dsir_irq_src_t;

    // Lines toward the CPU flag and mask logic
    typedef struct packed {
        logic line6;
        logic line7;
        logic line10;
        logic line11;
        logic dma_chan4_irq;
        logic dma_chan5_irq;
    } dsir_cpu_irq_t;

    // Reserved codes select nothing, so a misprogrammed channel fires only on an event still pending from its earlier code
    function automatic logic dsir_pick_event(input logic [3:0] code, input dsir_evt_t evt);
        logic hit;
        hit = 1'b0;
        case (code)
            DSIR_SYNC_P0_RX: hit = evt.port0_rx;
            DSIR_SYNC_P0_TX: hit = evt.port0_tx;
            DSIR_SYNC_P1_RX: hit = evt.port1_rx;
            DSIR_SYNC_P1_TX: hit = evt.port1_tx;
            DSIR_SYNC_TMR0: hit = evt.timer0_irq;
            DSIR_SYNC_EXT3: hit = evt.ext_irq3;
            DSIR_SYNC_TMR1: hit = evt.timer1_irq;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

endpackage

// >>> rtl/dsir_subbank.sv
`timescale 1ns/1ps
`include "dsir_regs.svh"

module dsir_subbank
    import dsir_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_wr,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic [DSIR_CHANS*4-1:0] o_sync_sel,
    output logic [DSIR_CHANS-1:0] o_irq_en,
    output logic [DSIR_CHANS-1:0] o_irq_mode
);

    logic [15:0] mem_q [0:`DSIR_SB_COUNT-1];
    logic in_range;

    assign in_range = (i_addr <= `DSIR_SB_LAST);

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < `DSIR_SB_COUNT; i++) begin
                mem_q[i] <= `DSIR_SB_DATA_RST;
            end
        end else if (i_wr && in_range) begin
            mem_q[i_addr[5:0]] <= i_wdata;
        end
    end

    // Holes above the last subaddress read as zero
    always_comb begin
        o_rdata = 16'h0000;
        if (in_range) begin
            o_rdata = mem_q[i_addr[5:0]];
        end
    end

    always_comb begin
        o_sync_sel = '0;
        o_irq_en = '0;
        o_irq_mode = '0;
        for (int c = 0; c < DSIR_CHANS; c++) begin
            o_sync_sel[c*4 +: 4] =
                mem_q[c*`DSIR_SB_STRIDE + `DSIR_SB_SFC_OFS][`DSIR_SFC_SYNC_MSB:`DSIR_SFC_SYNC_LSB]; // R01
            o_irq_en[c] = mem_q[c*`DSIR_SB_STRIDE + `DSIR_SB_MCR_OFS][`DSIR_MCR_IRQEN_BIT];
            o_irq_mode[c] = mem_q[c*`DSIR_SB_STRIDE + `DSIR_SB_MCR_OFS][`DSIR_MCR_IRQMODE_BIT];
        end
    end

endmodule // dsir_subbank

// >>> sim/dsir_chk.sv
`timescale 1ns/1ps
module dsir_chk
    import dsir_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire dsir_bus_req_t i_bus,
    input wire logic [15:0] o_rdata,
    input wire logic o_rd_valid,
    input wire logic o_hit,
    input wire dsir_irq_src_t i_src,
    input wire logic [DSIR_CHANS-1:0] o_chan_irq,
    input wire logic [1:0] o_route,
    input wire dsir_cpu_irq_t o_cpu_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Reserved routing code falls back to the peripheral sources
    wire all_on = (o_route == 2'h2);
    wire hi_on = (o_route == 2'h1) || all_on;

    rd_answer_a: assert property (i_bus.rd |=> o_rd_valid)
        else $error("read got no answer");
    rd_cause_a: assert property (o_rd_valid |-> $past(i_bus.rd))
        else $error("answer without read");
    unmapped_a: assert property (i_bus.rd && !o_hit |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    addr_hit_a: assert property (o_hit == (i_bus.addr inside {[8'h54:8'h57]}))
        else $error("decode wrong");
    route_reset_a: assert property ($rose(i_rst_n) |-> o_route == 2'h0 && o_cpu_irq == '0)
        else $error("reset state wrong");
    line6_a: assert property ($past(i_rst_n) |->
        o_cpu_irq.line6 == $past(all_on ? o_chan_irq[0] : i_src.rsvd6_irq)) else $error("line6 wrong");
    line7_a: assert property ($past(i_rst_n) |->
        o_cpu_irq.line7 == $past(all_on ? o_chan_irq[1] : i_src.timer1_irq)) else $error("line7 wrong");
    line10_a: assert property ($past(i_rst_n) |->
        o_cpu_irq.line10 == $past(hi_on ? o_chan_irq[2] : i_src.port1_rx_irq)) else $error("line10 wrong");
    line11_a: assert property ($past(i_rst_n) |->
        o_cpu_irq.line11 == $past(hi_on ? o_chan_irq[3] : i_src.port1_tx_irq)) else $error("line11 wrong");
    own_lines_a: assert property ($past(i_rst_n) |->
        {o_cpu_irq.dma_chan5_irq, o_cpu_irq.dma_chan4_irq} == $past(o_chan_irq[5:4]))
        else $error("own line wrong");

    cover property (o_route == 2'h1 && o_cpu_irq.line10);
    cover property (o_cpu_irq.dma_chan4_irq);
    cover property (o_rd_valid && o_rdata == 16'hF000);
endmodule // dsir_chk

bind dsir_top dsir_chk u_dsir_chk (.i_sys_clk, .i_rst_n, .i_bus, .o_rdata, .o_rd_valid, .o_hit, .i_src,
    .o_chan_irq, .o_route, .o_cpu_irq);

// >>> sim/dsir_irq_model.sv
`timescale 1ns/1ps
module dsir_irq_model
    import dsir_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clr,
    input wire dsir_evt_t i_fire,
    input wire dsir_irq_src_t i_raise,
    input wire dsir_cpu_irq_t i_cpu_irq,
    output dsir_evt_t o_evt,
    output dsir_irq_src_t o_src,
    output logic [5:0] o_flags
);
    // Peripherals pulse only when commanded; the testbench also programs reserved codes 3h and 7h
    assign o_evt = i_fire;
    assign o_src = i_raise;
    // Flags latch so a one-cycle line is never missed
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || i_clr) begin
            o_flags <= 6'h00;
        end else begin
            o_flags <= o_flags | 6'(i_cpu_irq);
        end
    end
endmodule // dsir_irq_model

// >>> sim/dsir_sync_and_irq_routing_tb.sv
`timescale 1ns/1ps
`define CK(n, a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module dsir_sync_and_irq_routing_tb
    import dsir_pkg::*;
;
    typedef struct packed { logic [3:0] code; logic [6:0] evt; } dsir_row_t;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic clr = 1'b0;
    dsir_bus_req_t bus = '0;
    dsir_evt_t fire = '0;
    dsir_evt_t evt;
    dsir_irq_src_t raise = '0;
    dsir_irq_src_t src;
    dsir_cpu_irq_t cpu;
    logic [5:0] half = '0, blk = '0, done = '0, go, chirq, flags;
    logic [15:0] rdata;
    logic [1:0] route;
    int mismatches = 0;
    int num_checks = 0;
    dsir_row_t rows [8] = '{'{4'h0, 7'h00}, '{4'h1, 7'h40}, '{4'h2, 7'h20}, '{4'h5, 7'h10},
        '{4'h6, 7'h08}, '{4'hD, 7'h04}, '{4'hE, 7'h02}, '{4'hF, 7'h01}};

    always #10 i_sys_clk = ~i_sys_clk;

    dsir_top u_dsir_top (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
        .o_rd_valid(), .o_hit(), .i_evt(evt), .i_src(src), .i_chan_half_end(half), .i_chan_block_end(blk),
        .i_chan_xfer_done(done), .o_chan_xfer_go(go), .o_chan_irq(chirq), .o_route(route), .o_cpu_irq(cpu));
    dsir_irq_model u_dsir_irq_model (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clr(clr), .i_fire(fire),
        .i_raise(raise), .i_cpu_irq(cpu), .o_evt(evt), .o_src(src), .o_flags(flags));

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_sys_clk) bus = '{1'b0, 1'b1, a, d};
        @(negedge i_sys_clk) bus = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge i_sys_clk) bus = '{1'b1, 1'b0, a, 16'h0000};
        @(negedge i_sys_clk) bus = '0;
        @(negedge i_sys_clk) `CK("rdata", rdata, e)
    endtask
    task automatic sbw(input logic [7:0] p, input logic [15:0] d);
        wr(8'h55, {8'h00, p});
        wr(8'h57, d);
    endtask
    task automatic pulse(input logic [6:0] e, input logic [5:0] d);
        @(negedge i_sys_clk) begin fire = dsir_evt_t'(e); done = d; end
        @(negedge i_sys_clk) begin fire = '0; done = '0; end
    endtask
    task automatic irq_case(input logic [1:0] r, input logic [3:0] s, input logic [5:0] h, input logic [5:0] b,
        input logic [5:0] c, input logic [5:0] e);
        wr(8'h54, {8'h00, r, 6'h3F});
        @(negedge i_sys_clk) begin clr = 1'b1; raise = dsir_irq_src_t'(s); half = h; blk = b; end
        @(negedge i_sys_clk) begin clr = 1'b0; raise = '0; half = '0; blk = '0; end
        `CK("chan irq", chirq, c)
        repeat (3) @(negedge i_sys_clk);
        `CK("route", route, r)
        `CK("cpu flags", flags, e)
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        `CK("route", route, 2'h0)
        rd(8'h54, 16'h0000);
        rd(8'h55, 16'h0000);
        $display("reset test done");
        wr(8'h55, 16'h0003);
        wr(8'h56, 16'hF000);
        rd(8'h55, 16'h0004);
        rd(8'h57, 16'h0000);
        rd(8'h55, 16'h0004);
        wr(8'h55, 16'h0003);
        rd(8'h56, 16'hF000);
        rd(8'h55, 16'h0004);
        rd(8'h58, 16'h0000);
        sbw(8'h28, 16'h1234);
        rd(8'h57, 16'h0000);
        wr(8'h54, 16'hAB3F);
        rd(8'h54, 16'hAB3F);
        $display("register test done");
        // Wrong events first, so a stray match shows before the right one sets pending
        foreach (rows[k]) begin
            sbw(8'h03, {rows[k].code, 12'h000});
            pulse(~rows[k].evt, 6'h00);
            `CK("go other", go[0], rows[k].code == 4'h0)
            pulse(rows[k].evt, 6'h00);
            `CK("go own", go[0], 1'b1)
            pulse(7'h00, 6'h01);
            `CK("go done", go[0], rows[k].code == 4'h0)
        end
        sbw(8'h03, 16'h3000);
        pulse(7'h7F, 6'h00);
        `CK("go reserved", go[0], 1'b0)
        sbw(8'h03, 16'h7000);
        pulse(7'h7F, 6'h00);
        `CK("go reserved", go[0], 1'b0)
        $display("sync test done");
        sbw(8'h09, 16'h4000);
        sbw(8'h0E, 16'h6000);
        sbw(8'h18, 16'h4000);
        irq_case(2'h0, 4'hA, 6'h00, 6'h3F, 6'h16, 6'h2A);
        irq_case(2'h1, 4'h0, 6'h06, 6'h00, 6'h04, 6'h08);
        irq_case(2'h2, 4'h0, 6'h00, 6'h0F, 6'h06, 6'h18);
        irq_case(2'h3, 4'h1, 6'h00, 6'h04, 6'h04, 6'h04);
        @(negedge i_sys_clk) i_rst_n = 1'b0;
        @(negedge i_sys_clk) i_rst_n = 1'b1;
        `CK("route", route, 2'h0)
        `CK("cpu lines", cpu, 6'h00)
        rd(8'h55, 16'h0000);
        $display("irq test done");
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge i_sys_clk);
        mismatches++;
        give_verdict();
    end
endmodule // dsir_sync_and_irq_routing_tb
